// File: hw/wdu_pkg.sv
// Constants, register map and types of the watchdog unit
// What this block and its software do
// [RULE1] Counter advances on dedicated 1 MHz oscillator ticks
// [RULE2] Restart instruction clears counter to zero
// [RULE3] Elapsed timeout without restart resets the device
// [RULE4] Control bits 7..5 read as zero
// [RULE5] Enable clears only while unlock bit set
// [RULE6] Unlock bit self-clears four CPU cycles later
// [RULE7] Control bit 3 switches the watchdog on/off
// [RULE8] Software writes unlock and enable together first
// [RULE9] Zero to enable within four cycles disables
// [RULE10] Select 0..7 gives 16K doubling to 2048K
// [RULE11] Software restarts before enabling the watchdog
// [RULE12] Software disables or restarts before changing select
// [RULE13] Oscillator and domain signals crossed through synchronisers
// [RULE14] Disabled watchdog holds counter zero, no reset
package wdu_pkg;
  // Bus decode
  localparam int          ADDR_W         = 12;
  localparam logic [7:0]  CTRL_INDEX     = 8'h21;
  localparam logic [7:0]  STAT_INDEX     = 8'h22;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_INDEX, 2'h0};
  // Control register layout
  localparam int          CTRL_W         = 8;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          UNLOCK_BIT     = 4;
  localparam int          ENABLE_BIT     = 3;
  localparam int          SEL_MSB        = 2;
  localparam int          SEL_LSB        = 0;
  // Status register layout
  localparam int          STAT_RUN_BIT   = 0;
  localparam int          STAT_TO_BIT    = 1;
  localparam int          STAT_CNT_LSB   = 8;
  // Timing
  localparam int          OSC_NOM_HZ     = 1_000_000;
  localparam int          HCLK_HZ        = 100_000_000;
  localparam int          UNLOCK_CYCLES  = 4;
  localparam logic [2:0]  UNLOCK_LOAD    = 3'(UNLOCK_CYCLES);
  localparam int          BASE_TICKS     = 16384;
  localparam int          CNT_W          = 22;
  // Bus data-phase states
  typedef enum logic [3:0] {
    BS_IDLE   = 4'b0001,
    BS_WRITE  = 4'b0010,
    BS_RFETCH = 4'b0100,
    BS_RDONE  = 4'b1000
  } wdu_bus_st_e;
endpackage

// File: hw/wdu_cnt_if.sv
// Link between the control logic and the timeout counter
`timescale 1ns/100ps
`default_nettype none
interface wdu_cnt_if;
  import wdu_pkg::*;
  logic             tick;
  logic             enable;
  logic             restart;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] count;
  logic             expire;
  modport ctrl (output tick, output enable, output restart, output limit, input count, input expire);
  modport cnt  (input tick, input enable, input restart, input limit, output count, output expire);
endinterface
`default_nettype wire

// File: hw/wdu_counter.sv
// Timeout counter stepped by oscillator ticks
`timescale 1ns/100ps
`default_nettype none
module wdu_counter
  import wdu_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control side
  wdu_cnt_if.cnt   cif
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             expire_r;
  logic             last_tick;

  // Timeout reached on the tick that completes the period
  assign last_tick = cif.tick && (count_r == cif.limit - CNT_W'(1));

  // Restart and disable both force zero; disable has no expiry
  always_comb begin
    count_nxt = count_r;
    if (!cif.enable) begin
      count_nxt = '0; // RULE14
    end else if (cif.restart) begin
      count_nxt = '0; // RULE2
    end else if (last_tick) begin
      count_nxt = '0;
    end else if (cif.tick) begin
      count_nxt = count_r + CNT_W'(1); // RULE1
    end
  end

  // Counter and registered expiry pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r  <= '0;
      expire_r <= 1'b0;
    end else begin
      count_r  <= count_nxt;
      expire_r <= cif.enable && !cif.restart && last_tick; // RULE3
    end
  end

  assign cif.count  = count_r;
  assign cif.expire = expire_r;
endmodule
`default_nettype wire

// File: hw/wdu_top.sv
// Watchdog unit top: AHB-Lite register slave, unlock timer, oscillator sync
`timescale 1ns/100ps
`default_nettype none
module wdu_top
  import wdu_pkg::*;
#(
  parameter int TICKS_BASE = BASE_TICKS
)(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Watchdog oscillator and CPU events
  input  wire logic        dog_osc,
  input  wire logic        dog_restart_instruction,
  // Device reset request
  output logic             dog_reset_out
);
  // Bus state
  wdu_bus_st_e       bus_st_r;
  wdu_bus_st_e       bus_st_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0]       hrdata_r;
  logic              accept;
  logic              wr_ctrl;
  logic              wr_stat;
  logic [31:0]       rd_value;
  logic              rd_is_ctrl;
  logic              rd_is_stat;

  // Watchdog control state
  logic              enable_r;
  logic              enable_nxt;
  logic [2:0]        sel_r;
  logic [2:0]        unlock_cnt_r;
  logic [2:0]        unlock_cnt_nxt;
  logic              unlock_on;
  logic              timeout_flag_r;
  logic              reset_out_r;
  logic [7:0]        ctrl_view;
  logic [31:0]       stat_view;

  // Oscillator synchroniser
  logic              osc_s1_r;
  logic              osc_s2_r;
  logic              osc_s3_r;

  // Link to the counter; the counter owns count and expiry
  wdu_cnt_if cif ();

  // Address phase taken when selected, NONSEQ or SEQ (htrans[1] set, so BUSY is not taken) and bus ready
  assign accept    = hsel && htrans[1] && hready;
  // Reads take one wait state so data always come from a flip-flop
  // Trade-off: one extra cycle per read, no path from the mux to hrdata
  assign hreadyout = (bus_st_r != BS_RFETCH);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Next data-phase state
  // Reads always pass the wait state; writes finish in one cycle
  always_comb begin
    bus_st_nxt = BS_IDLE;
    case (bus_st_r)
      BS_RFETCH: begin
        bus_st_nxt = BS_RDONE;
      end
      default: begin
        if (accept && hwrite) begin
          bus_st_nxt = BS_WRITE;
        end else if (accept) begin
          bus_st_nxt = BS_RFETCH;
        end else begin
          bus_st_nxt = BS_IDLE;
        end
      end
    endcase
  end

  // Bus state and captured address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_r <= BS_IDLE;
      addr_r   <= '0;
    end else begin
      bus_st_r <= bus_st_nxt;
      if (accept) begin
        addr_r <= haddr[ADDR_W-1:0];
      end
    end
  end

  // Write decode; unmapped addresses are silently ignored
  // Writes land at the data-phase edge, using the captured address
  assign wr_ctrl    = (bus_st_r == BS_WRITE) && (addr_r == CTRL_ADDR);
  assign wr_stat    = (bus_st_r == BS_WRITE) && (addr_r == STAT_ADDR);
  assign rd_is_ctrl = (addr_r == CTRL_ADDR);
  assign rd_is_stat = (addr_r == STAT_ADDR);

  // Register views; top control bits tied low
  assign unlock_on = (unlock_cnt_r != 3'h0);
  assign ctrl_view = {3'h0, unlock_on, enable_r, sel_r}; // RULE4
  assign stat_view = {2'h0, cif.count, 6'h00, timeout_flag_r, enable_r};

  // Read mux; unmapped reads return zero
  // Only the low byte of the control word carries fields
  always_comb begin
    if (rd_is_ctrl) begin
      rd_value = {24'h000000, ctrl_view};
    end else if (rd_is_stat) begin
      rd_value = stat_view;
    end else begin
      rd_value = 32'h00000000;
    end
  end

  // Read data register, loaded in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (bus_st_r == BS_RFETCH) begin
      hrdata_r <= rd_value;
    end
  end

  // Unlock window: loaded by a write with unlock and enable both one
  // Load wins over the decrement, so a repeated unlock write restarts
  // the window rather than extending a stale one
  always_comb begin
    unlock_cnt_nxt = unlock_cnt_r;
    if (unlock_on) begin
      unlock_cnt_nxt = unlock_cnt_r - 3'h1; // RULE6
    end
    if (wr_ctrl && hwdata[UNLOCK_BIT] && hwdata[ENABLE_BIT]) begin
      unlock_cnt_nxt = UNLOCK_LOAD; // RULE8
    end
  end

  // Enable: set freely, cleared only inside an open unlock window
  // A write with enable one always wins, so setting needs no unlock
  always_comb begin
    enable_nxt = enable_r;
    if (wr_ctrl && hwdata[ENABLE_BIT]) begin
      enable_nxt = 1'b1; // RULE7
    end else if (wr_ctrl && unlock_on) begin
      enable_nxt = 1'b0; // RULE5 RULE9
    end
  end

  // Control register fields
  // Select is always written; only enable is guarded by the window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r     <= CTRL_RESET[ENABLE_BIT];
      sel_r        <= CTRL_RESET[SEL_MSB:SEL_LSB];
      unlock_cnt_r <= 3'h0;
    end else begin
      enable_r     <= enable_nxt;
      unlock_cnt_r <= unlock_cnt_nxt;
      if (wr_ctrl) begin
        sel_r <= hwdata[SEL_MSB:SEL_LSB];
      end
    end
  end

  // Sticky timeout flag; write one clears, a new expiry wins
  // Set wins so an expiry is never lost to a racing clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_flag_r <= 1'b0;
    end else begin
      timeout_flag_r <= cif.expire || (timeout_flag_r && !(wr_stat && hwdata[STAT_TO_BIT]));
    end
  end

  // Oscillator edge; only the second stage and later are looked at
  // The oscillator is a slow level: it must stay high and low for
  // at least two hclk cycles each, or ticks are lost
  // Third stage only holds the previous value for the edge test
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= dog_osc; // RULE13
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // Counter controls; period is base count shifted by the select code
  // A select change while counting can leave count above the new limit;
  // software restarts or disables first, the block cannot tell intent
  assign cif.tick    = osc_s2_r && !osc_s3_r; // RULE1
  assign cif.enable  = enable_r;
  assign cif.restart = dog_restart_instruction; // RULE2
  assign cif.limit   = CNT_W'(TICKS_BASE) << sel_r; // RULE10

  // Timeout counter
  wdu_counter u_counter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cif     (cif.cnt)
  );

  // Device reset request, one registered pulse per expiry
  // Only a request: the block itself is reset through hresetn
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_out_r <= 1'b0;
    end else begin
      reset_out_r <= cif.expire; // RULE3
    end
  end

  assign dog_reset_out = reset_out_r;
endmodule
`default_nettype wire

// File: sim/wdu_top_asserts.sv
// Port-level checker for the watchdog unit
`timescale 1ns/100ps
`default_nettype none
module wdu_top_asserts
  import wdu_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Watchdog side
  input wire logic        dog_osc,
  input wire logic        dog_restart_instruction,
  input wire logic        dog_reset_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Accepted transfers and decoded places
  wire logic take   = hsel && htrans[1] && hready;
  wire logic rd_ctl = take && !hwrite && haddr[11:0] == CTRL_ADDR;
  wire logic rd_unm = take && !hwrite && haddr[11:0] != CTRL_ADDR && haddr[11:0] != STAT_ADDR;
  resp_okay_a: assert property (hresp == 1'b0) else $error("bus response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  reset_pulse_a: assert property (dog_reset_out |=> !dog_reset_out) else $error("reset not one cycle");
  restart_quiet_a: assert property (dog_restart_instruction |-> ##2 !dog_reset_out [*2])
    else $error("reset right after restart");
  reserved_zero_a: assert property (rd_ctl |-> ##2 hrdata[31:5] == 27'h0) else $error("reserved bits set");
  unmapped_zero_a: assert property (rd_unm |-> ##2 hrdata == 32'h0) else $error("unmapped read nonzero");
  osc_quiet_a: assert property (!dog_osc [*8] |=> !dog_reset_out) else $error("reset without ticks");
endmodule
bind wdu_top wdu_top_asserts i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .dog_osc(dog_osc), .dog_restart_instruction(dog_restart_instruction),
  .dog_reset_out(dog_reset_out));
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the watchdog unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import wdu_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, osc = 0, rst_ins = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_q, r;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, dog_rst, rdy_q;
  int          err_count = 0, samples_checked = 0, resets = 0;
  wdu_top #(.TICKS_BASE(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dog_osc(osc),
    .dog_restart_instruction(rst_ins), .dog_reset_out(dog_rst));
  always #5 hclk = ~hclk;
  // Bus answer held from the falling edge, so the rising edge sees settled values
  always @(negedge hclk) begin
    rdy_q = hreadyout;
    rd_q = hrdata;
  end
  always @(posedge hclk) if (dog_rst === 1'b1) resets++;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer, waits on hready in both phases
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= w; hsel <= 1'b1;
    do @(posedge hclk); while (rdy_q !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (rdy_q !== 1'b1);
    r = rd_q;
  endtask
  task tick(input int n);
    repeat (n) begin
      osc <= 1'b1; repeat (4) @(posedge hclk);
      osc <= 1'b0; repeat (4) @(posedge hclk);
    end
  endtask
  task restart;
    rst_ins <= 1'b1; @(posedge hclk); rst_ins <= 1'b0; @(posedge hclk);
  endtask
  task end_of_test;
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Timeout period per select code, restart honoured mid-count
  task timeouts;
    for (int s = 0; s < 8; s++) begin
      xfer(1, CTRL_ADDR, 32'h8 | s); restart; resets = 0;
      tick((4 << s) - 1); chk(resets, 0);
      tick(1); chk(resets, 1);
    end
    restart;
    xfer(1, CTRL_ADDR, 32'h8);
    restart; tick(3); restart; tick(3); chk(resets, 1);
    tick(1); chk(resets, 2);
    xfer(0, STAT_ADDR, 0);
    chk(r, 32'h3);
    xfer(1, STAT_ADDR, 32'h2);
    xfer(0, STAT_ADDR, 0);
    chk(r, 32'h1);
  endtask
  // Turn-off sequence: late clear refused, prompt clear obeyed
  task turn_off;
    xfer(1, CTRL_ADDR, 32'h18); repeat (8) @(posedge hclk);
    xfer(0, CTRL_ADDR, 0); chk(r, 32'h08);
    xfer(1, CTRL_ADDR, 0); xfer(0, CTRL_ADDR, 0); chk(r, 32'h08);
    xfer(1, CTRL_ADDR, 32'h18); xfer(1, CTRL_ADDR, 0);
    xfer(0, CTRL_ADDR, 0);
    chk(r, 32'h10);
    repeat (4) @(posedge hclk);
    xfer(0, CTRL_ADDR, 0);
    chk(r, 32'h00);
    resets = 0; tick(40); chk(resets, 0);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1; @(posedge hclk);
    xfer(0, CTRL_ADDR, 0); chk(r, 32'h0);
    xfer(0, 12'h100, 0); chk(r, 32'h0);
    xfer(1, CTRL_ADDR, 32'hFFFF_FFEF); xfer(0, CTRL_ADDR, 0); chk(r, 32'h0F);
    xfer(1, CTRL_ADDR, 0); xfer(0, CTRL_ADDR, 0); chk(r, 32'h08);
    timeouts;
    turn_off;
    end_of_test;
  end
  // Hang guard well beyond the expected run
  initial begin
    repeat (40000) @(posedge hclk);
    err_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
